//--- rtl/sdram_bank_pkg.sv
// Constants, commands and states of the per-bank command state machine.
// Assumes command pins are sampled on the rising edge of one system clock.
`default_nettype none
package sdram_bank_pkg;
  typedef enum logic [3:0] {
    device_deselect_cmd, no_operation_cmd, burst_stop_cmd, column_read_cmd,
    read_autoprecharge_cmd, column_write_cmd, write_autoprecharge_cmd,
    bank_activate_cmd, bank_precharge_cmd, all_bank_precharge_cmd,
    refresh_cmd, mode_register_load_cmd
  } cmd_t;

  typedef enum logic [3:0] {
    st_idle           = 4'h0,
    st_row_active     = 4'h1,
    st_burst_read     = 4'h3,
    st_read_autopre   = 4'h2,
    st_row_precharge  = 4'h6,
    st_burst_write    = 4'h5,
    st_write_recovery = 4'h4,
    st_power_down     = 4'h8,
    st_self_refresh   = 4'hc
  } bank_state_t;

  // Pin vector layout after the synchroniser
  localparam int PIN_W       = 17;
  localparam int PIN_CKE     = 16;
  localparam int PIN_CS_N    = 15;
  localparam int PIN_RAS_N   = 14;
  localparam int PIN_CAS_N   = 13;
  localparam int PIN_WE_N    = 12;
  localparam int PIN_BANK    = 11;
  localparam int PIN_A10     = 10;
  localparam int ROW_W       = 11;
  localparam int COL_W       = 8;

  // Operating code fields
  localparam int OP_BL_LSB   = 0;
  localparam int OP_CL_LSB   = 4;
  localparam logic [2:0] BL_FULL_PAGE = 3'h7;
  localparam logic [2:0] BL_RESET     = 3'h0;
  localparam logic [2:0] CL_RESET     = 3'h2;
  localparam logic [2:0] CL_THREE     = 3'h3;

  // Transient state lengths in cycles
  localparam logic [3:0] PRECHARGE_CYCLES = 4'h2;
  localparam logic [3:0] RECOVERY_CYCLES  = 4'h1;

  // Beats of a burst for a length code
  function automatic logic [8:0] burst_beats(input logic [2:0] code);
    case (code)
      3'h1:    burst_beats = 9'h002;
      3'h2:    burst_beats = 9'h004;
      3'h3:    burst_beats = 9'h008;
      3'h7:    burst_beats = 9'h100;
      default: burst_beats = 9'h001;
    endcase
  endfunction : burst_beats
endpackage : sdram_bank_pkg
`default_nettype wire

//--- rtl/sdram_cmd_decode.sv
// Decoder from the four command strobes and A10 to a command code.
// Assumes the strobes are already synchronised to the system clock.
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_decode (
  // Command strobes
  input  wire logic                 cs_n,
  input  wire logic                 ras_n,
  input  wire logic                 cas_n,
  input  wire logic                 we_n,
  input  wire logic                 a10,
  // Decoded command
  output sdram_bank_pkg::cmd_t      cmd
);
  import sdram_bank_pkg::*;

  always_comb begin
    if (cs_n) begin
      cmd = device_deselect_cmd;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h7:    cmd = no_operation_cmd;
        3'h6:    cmd = burst_stop_cmd;
        3'h5:    cmd = a10 ? read_autoprecharge_cmd : column_read_cmd;
        3'h4:    cmd = a10 ? write_autoprecharge_cmd : column_write_cmd;
        3'h3:    cmd = bank_activate_cmd;
        3'h2:    cmd = a10 ? all_bank_precharge_cmd : bank_precharge_cmd;
        3'h1:    cmd = refresh_cmd;
        default: cmd = mode_register_load_cmd;
      endcase
    end
  end
endmodule : sdram_cmd_decode
`default_nettype wire

//--- rtl/sdram_bank_fsm.sv
// Command state machine of one bank of a two-bank synchronous DRAM.
// Assumes the controller keeps its own ordering obligations.
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_fsm #(
  parameter logic BANK_ID = 1'b0
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       nrst,
  // Command pins
  input  wire logic                       cke,
  input  wire logic                       cs_n,
  input  wire logic                       ras_n,
  input  wire logic                       cas_n,
  input  wire logic                       we_n,
  input  wire logic                       bank_sel,
  input  wire logic [10:0]                addr,
  // Bank status
  output sdram_bank_pkg::bank_state_t     state,
  output logic [10:0]                     open_row,
  output logic [7:0]                      burst_col,
  output logic [2:0]                      burst_len_code,
  output logic [2:0]                      cas_latency,
  // Data path control
  output logic                            dq_out_en,
  output logic                            write_beat,
  // Events
  output logic                            illegal_cmd,
  output logic                            refresh_pulse
);
  import sdram_bank_pkg::*;

  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_q;
  logic             cke_prev;
  cmd_t             cmd;
  logic [8:0]       burst_left;
  logic             full_page;
  logic             write_autopre;
  logic [3:0]       wait_cnt;
  logic [2:0]       rd_pipe;

  // Two-stage synchroniser on all pins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= '0;
      pin_q    <= '0;
    end else begin
      pin_meta <= {cke, cs_n, ras_n, cas_n, we_n, bank_sel, addr};
      pin_q    <= pin_meta;
    end
  end

  sdram_cmd_decode u_decode (
    .cs_n  (pin_q[PIN_CS_N]),
    .ras_n (pin_q[PIN_RAS_N]),
    .cas_n (pin_q[PIN_CAS_N]),
    .we_n  (pin_q[PIN_WE_N]),
    .a10   (pin_q[PIN_A10]),
    .cmd   (cmd)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cke_prev <= 1'b0;
    end else begin
      cke_prev <= pin_q[PIN_CKE];
    end
  end

  logic cke_now;
  logic live;
  logic hit;
  logic quiet;
  logic stop_cmd;
  logic rd_cmd;
  logic wr_cmd;
  logic pre_cmd;
  logic act_cmd;
  logic ref_cmd;
  logic mrs_cmd;
  logic last_beat;
  logic wait_done;
  logic reading;
  logic start_burst;
  logic [7:0] col_addr;

  assign cke_now   = pin_q[PIN_CKE];
  // Commands count only with clock enable high the cycle before
  assign live      = cke_prev;
  assign hit       = (pin_q[PIN_BANK] == BANK_ID);
  assign col_addr  = pin_q[COL_W-1:0];
  assign quiet     = live && (cmd == device_deselect_cmd || cmd == no_operation_cmd);
  assign stop_cmd  = live && (cmd == burst_stop_cmd);
  assign rd_cmd    = live && hit && (cmd == column_read_cmd || cmd == read_autoprecharge_cmd);
  assign wr_cmd    = live && hit &&
                     (cmd == column_write_cmd || cmd == write_autoprecharge_cmd);
  assign pre_cmd   = live && ((hit && cmd == bank_precharge_cmd) ||
                     cmd == all_bank_precharge_cmd);
  assign act_cmd   = live && hit && (cmd == bank_activate_cmd);
  assign ref_cmd   = live && (cmd == refresh_cmd);
  assign mrs_cmd   = live && (cmd == mode_register_load_cmd);
  assign last_beat = (burst_left == 9'h000) && !full_page;
  assign wait_done = wait_cnt == ((state == st_row_precharge) ? PRECHARGE_CYCLES - 4'h1 :
                     RECOVERY_CYCLES - 4'h1);
  assign reading   = state == st_burst_read || state == st_read_autopre;
  assign start_burst = (rd_cmd || wr_cmd) && (state == st_row_active ||
                       state == st_burst_read || state == st_burst_write ||
                       state == st_write_recovery);
  assign write_beat = live && state == st_burst_write;

  // Bank state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          if ((quiet || stop_cmd) && !cke_now) begin
            state <= st_power_down;
          end else if (ref_cmd && !cke_now) begin
            state <= st_self_refresh;
          end else if (act_cmd) begin
            state <= st_row_active;
          end
        end
        st_power_down, st_self_refresh: begin
          if (cke_now) begin
            state <= st_idle;
          end
        end
        st_row_active: begin
          if (rd_cmd) begin
            state <= pin_q[PIN_A10] ? st_read_autopre : st_burst_read;
          end else if (wr_cmd) begin
            state <= st_burst_write;
          end else if (pre_cmd) begin
            state <= st_row_precharge;
          end
        end
        st_burst_read, st_burst_write, st_write_recovery: begin
          if (rd_cmd) begin
            state <= pin_q[PIN_A10] ? st_read_autopre : st_burst_read;
          end else if (wr_cmd) begin
            state <= st_burst_write;
          end else if (state == st_write_recovery) begin
            if (live && wait_done) begin
              state <= write_autopre ? st_row_precharge : st_row_active;
            end
          end else if (pre_cmd) begin
            state <= st_row_precharge;
          end else if (stop_cmd) begin
            state <= st_row_active;
          end else if (live && last_beat) begin
            state <= (state == st_burst_read) ? st_row_active :
                     st_write_recovery;
          end
        end
        st_read_autopre: begin
          if (live && last_beat) begin
            state <= st_row_precharge;
          end
        end
        st_row_precharge: begin
          if (live && wait_done) begin
            state <= st_idle;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // Open row and mode register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      open_row       <= '0;
      burst_len_code <= BL_RESET;
      cas_latency    <= CL_RESET;
    end else begin
      if (state == st_idle && act_cmd) begin
        open_row <= pin_q[ROW_W-1:0];
      end
      if (state == st_idle && mrs_cmd) begin
        burst_len_code <= pin_q[OP_BL_LSB +: 3];
        cas_latency    <= pin_q[OP_CL_LSB +: 3];
      end
    end
  end

  // Burst beat counter and column
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      burst_left    <= '0;
      burst_col     <= '0;
      full_page     <= 1'b0;
      write_autopre <= 1'b0;
    end else if (start_burst) begin
      burst_left    <= burst_beats(burst_len_code) - 9'h001;
      burst_col     <= col_addr;
      full_page     <= burst_len_code == BL_FULL_PAGE;
      write_autopre <= cmd == write_autoprecharge_cmd;
    end else if (live && (reading || state == st_burst_write)) begin
      burst_col <= burst_col + 8'h01;
      if (!full_page && burst_left != 9'h000) begin
        burst_left <= burst_left - 9'h001;
      end
    end
  end

  // Precharge and recovery timer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wait_cnt <= '0;
    end else if ((state == st_row_precharge || state == st_write_recovery) && live
                 && !start_burst) begin
      wait_cnt <= wait_done ? 4'h0 : wait_cnt + 4'h1;
    end else if (live) begin
      wait_cnt <= '0;
    end
  end

  // Read output window delayed by CAS latency
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_pipe   <= '0;
      dq_out_en <= 1'b0;
    end else if (live) begin
      rd_pipe   <= {rd_pipe[1:0], reading};
      dq_out_en <= (cas_latency == CL_THREE) ? rd_pipe[1] : rd_pipe[0];
    end
  end

  // Illegal command and refresh events
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      illegal_cmd   <= 1'b0;
      refresh_pulse <= 1'b0;
    end else begin
      refresh_pulse <= state == st_idle && ref_cmd && cke_now;
      case (state)
        st_idle:         illegal_cmd <= rd_cmd || wr_cmd;
        st_row_active, st_burst_read, st_burst_write, st_write_recovery:
          illegal_cmd <= act_cmd || ref_cmd || mrs_cmd;
        st_read_autopre: illegal_cmd <= live && !quiet;
        default:         illegal_cmd <= 1'b0;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  idle_quiet_a: assert property (state == st_idle && quiet && cke_now |=>
    state == st_idle) else $error("idle left on quiet command");
  pdown_entry_a: assert property (state == st_idle && quiet && !cke_now |=>
    state == st_power_down) else $error("power-down not entered");
  activate_row_a: assert property (state == st_idle && act_cmd |=>
    state == st_row_active && open_row == $past(pin_q[ROW_W-1:0]))
    else $error("activate did not open row");
  active_pre_a: assert property (state == st_row_active && pre_cmd && !rd_cmd
    && !wr_cmd |=> state == st_row_precharge) else $error("precharge ignored in row active");
  read_done_a: assert property (state == st_burst_read && quiet && last_beat |=>
    state == st_row_active) else $error("read burst did not finish");
  read_stop_a: assert property (state == st_burst_read && stop_cmd |=>
    state == st_row_active) else $error("burst stop ignored in read");
  read_restart_a: assert property (state == st_burst_read && rd_cmd |=>
    reading && burst_col == $past(col_addr)) else $error("read restart wrong");
  read_to_write_a: assert property (state == st_burst_read && wr_cmd |=>
    state == st_burst_write) else $error("write did not cut read");
  read_pre_a: assert property (state == st_burst_read && pre_cmd && !rd_cmd && !wr_cmd
    |=> state == st_row_precharge) else $error("precharge did not cut read");
  write_done_a: assert property (state == st_burst_write && quiet && last_beat |=>
    state == st_write_recovery) else $error("write burst did not finish");
  write_stop_a: assert property (state == st_burst_write && stop_cmd |=>
    state == st_row_active) else $error("burst stop ignored in write");
  write_to_read_a: assert property (state == st_burst_write && rd_cmd |=>
    reading && burst_col == $past(col_addr)) else $error("read did not cut write");
  write_restart_a: assert property (state == st_burst_write && wr_cmd |=>
    state == st_burst_write && burst_col == $past(col_addr)) else $error("write restart wrong");
  write_pre_a: assert property (state == st_burst_write && pre_cmd && !rd_cmd
    && !wr_cmd |=> state == st_row_precharge) else $error("precharge did not cut write");
  autopre_done_a: assert property (state == st_read_autopre && quiet && last_beat |=>
    state == st_row_precharge) else $error("auto-precharge missing");
  dq_drain_a: assert property (reading && live && cas_latency == CL_THREE ##1
    (live && !reading)[*3] |-> dq_out_en ##1 (!dq_out_en || !live))
    else $error("output window length wrong");
  pdown_hold_a: assert property (state == st_power_down && !cke_now ##1 !cke_now
    |-> state == st_power_down) else $error("power-down left with clock enable low");

  read_burst_c: cover property (state == st_burst_read ##1 state == st_row_active);
  write_recover_c: cover property (state == st_write_recovery ##1 state == st_row_active);
  autopre_c: cover property (state == st_read_autopre ##1 state == st_row_precharge);
  pdown_c: cover property (state == st_power_down ##1 state == st_idle);
endmodule : sdram_bank_fsm
`default_nettype wire

//--- bench/sdram_ctrl_model.sv
// Controller-side driver of the command bus: turns a requested command into pin levels.
// Assumes the bench changes its request just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  // Request from the bench
  input  var  sdram_bank_pkg::cmd_t req_cmd,
  input  wire logic                 req_bank,
  input  wire logic [10:0]          req_addr,
  input  wire logic                 req_cke,
  // Command pins
  output logic                      cke,
  output logic                      cs_n,
  output logic                      ras_n,
  output logic                      cas_n,
  output logic                      we_n,
  output logic                      bank_sel,
  output logic [10:0]               addr
);
  import sdram_bank_pkg::*;
  logic [10:0] filler;
  logic [2:0]  strobe;
  logic        idle_bus;
  logic        a10;
  // Don't-care lines change every cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      filler <= 11'h2a5;
    end else begin
      filler <= ~filler;
    end
  end
  always_comb begin
    case (req_cmd)
      burst_stop_cmd:                             strobe = 3'h6;
      column_read_cmd, read_autoprecharge_cmd:    strobe = 3'h5;
      column_write_cmd, write_autoprecharge_cmd:  strobe = 3'h4;
      bank_activate_cmd:                          strobe = 3'h3;
      bank_precharge_cmd, all_bank_precharge_cmd: strobe = 3'h2;
      refresh_cmd:                                strobe = 3'h1;
      mode_register_load_cmd:                     strobe = 3'h0;
      default:                                    strobe = 3'h7;
    endcase
  end
  assign a10 = req_cmd inside {read_autoprecharge_cmd, write_autoprecharge_cmd,
                               all_bank_precharge_cmd};
  assign idle_bus = req_cmd inside {device_deselect_cmd, no_operation_cmd, burst_stop_cmd};
  assign cke = req_cke;
  assign cs_n = (req_cmd == device_deselect_cmd);
  assign {ras_n, cas_n, we_n} = cs_n ? filler[2:0] : strobe;
  assign bank_sel = idle_bus ? filler[0] : req_bank;
  always_comb begin
    if (idle_bus) begin
      addr = filler;
    end else if (strobe == 3'h5 || strobe == 3'h4 || strobe == 3'h2) begin
      addr = {a10, req_addr[9:0]};
    end else begin
      addr = req_addr;
    end
  end
endmodule : sdram_ctrl_model
`default_nettype wire

//--- bench/sdram_bank_command_state_machine_tb.sv
// Self-checking bench of one bank state machine driven through the controller model.
// Assumes the bank answers for bank select 0 and acts three edges after a command.
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_command_state_machine_tb;
  import sdram_bank_pkg::*;
  typedef struct {cmd_t c; logic b; logic [10:0] a; bank_state_t s; logic [1:0] ev;} row_t;
  logic sys_clk, nrst, req_bank, req_cke, cke, cs_n, ras_n, cas_n, we_n, bank_sel;
  logic [10:0] req_addr, addr, open_row;
  cmd_t req_cmd;
  bank_state_t state;
  logic [7:0] burst_col;
  logic [2:0] burst_len_code, cas_latency;
  logic dq_out_en, write_beat, illegal_cmd, refresh_pulse;
  int err_count, n_compared;
  row_t rows [27] = '{
    '{mode_register_load_cmd, 0, 11'h027, st_idle, 0}, '{no_operation_cmd, 0, 0, st_idle, 0},
    '{burst_stop_cmd, 0, 0, st_idle, 0}, '{device_deselect_cmd, 0, 0, st_idle, 0},
    '{column_read_cmd, 0, 11'h010, st_idle, 2}, '{write_autoprecharge_cmd, 0, 0, st_idle, 2},
    '{bank_precharge_cmd, 0, 0, st_idle, 0}, '{refresh_cmd, 0, 0, st_idle, 1},
    '{bank_activate_cmd, 1, 11'h0aa, st_idle, 0},
    '{bank_activate_cmd, 0, 11'h155, st_row_active, 0},
    '{bank_activate_cmd, 0, 11'h0aa, st_row_active, 2}, '{refresh_cmd, 0, 0, st_row_active, 2},
    '{mode_register_load_cmd, 0, 11'h021, st_row_active, 2},
    '{burst_stop_cmd, 0, 0, st_row_active, 0}, '{column_read_cmd, 1, 11'h033, st_row_active, 0},
    '{column_read_cmd, 0, 11'h010, st_burst_read, 0},
    '{column_read_cmd, 0, 11'h040, st_burst_read, 0},
    '{column_write_cmd, 0, 11'h080, st_burst_write, 0},
    '{column_write_cmd, 0, 11'h0a0, st_burst_write, 0},
    '{column_read_cmd, 0, 11'h0c0, st_burst_read, 0}, '{burst_stop_cmd, 0, 0, st_row_active, 0},
    '{column_write_cmd, 0, 11'h020, st_burst_write, 0}, '{burst_stop_cmd, 0, 0, st_row_active, 0},
    '{column_read_cmd, 0, 11'h030, st_burst_read, 0},
    '{bank_precharge_cmd, 0, 0, st_row_precharge, 0},
    '{bank_activate_cmd, 0, 11'h2aa, st_row_active, 0},
    '{column_write_cmd, 0, 11'h050, st_burst_write, 0}};

  sdram_ctrl_model u_sdram_ctrl_model (.sys_clk(sys_clk), .nrst(nrst), .req_cmd(req_cmd),
    .req_bank(req_bank), .req_addr(req_addr), .req_cke(req_cke), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_sel(bank_sel), .addr(addr));
  sdram_bank_fsm u_sdram_bank_fsm (.sys_clk(sys_clk), .nrst(nrst), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_sel(bank_sel), .addr(addr),
    .state(state), .open_row(open_row), .burst_col(burst_col),
    .burst_len_code(burst_len_code), .cas_latency(cas_latency), .dq_out_en(dq_out_en),
    .write_beat(write_beat), .illegal_cmd(illegal_cmd), .refresh_pulse(refresh_pulse));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Holds a command on the pins for one cycle, then no-op
  task automatic cmd(input cmd_t c, input logic b, input logic [10:0] a);
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    @(posedge sys_clk);
    #2 req_cmd = no_operation_cmd;
  endtask : cmd

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : tick

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (2000) @(posedge sys_clk);
    err_count++;
    finish_test();
  end

  initial begin
    err_count = 0;
    n_compared = 0;
    nrst = 1'b0;
    req_cmd = no_operation_cmd;
    req_bank = 1'b0;
    req_addr = 11'h000;
    req_cke = 1'b1;
    tick(12);
    nrst = 1'b1;
    tick(3);
    foreach (rows[i]) begin
      cmd(rows[i].c, rows[i].b, rows[i].a);
      tick(2);
      check(state, rows[i].s);
      check({illegal_cmd, refresh_pulse}, rows[i].ev);
      if (rows[i].s inside {st_burst_read, st_burst_write}) begin
        check(burst_col, rows[i].a[7:0]);
      end
      if (rows[i].c == bank_activate_cmd && rows[i].ev == 0 && rows[i].b == 0 &&
          rows[i].s == st_row_active) begin
        check(open_row, rows[i].a);
      end
      tick(1);
    end
    check({burst_len_code, cas_latency}, 6'h3a);
    cmd(all_bank_precharge_cmd, 1'b1, 11'h000);
    tick(2);
    check(state, st_row_precharge);
    tick(4);
    // Two-beat bursts: completion paths
    cmd(mode_register_load_cmd, 1'b0, 11'h021);
    tick(3);
    check(burst_len_code, 3'h1);
    cmd(bank_activate_cmd, 1'b0, 11'h123);
    tick(3);
    cmd(column_read_cmd, 1'b0, 11'h070);
    tick(2);
    check(state, st_burst_read);
    tick(1);
    check(burst_col, 8'h71);
    tick(1);
    check(state, st_row_active);
    check(dq_out_en, 1'b1);
    tick(2);
    check(dq_out_en, 1'b0);
    cmd(column_write_cmd, 1'b0, 11'h090);
    tick(2);
    check(write_beat, 1'b1);
    tick(2);
    check(state, st_write_recovery);
    tick(2);
    check(state, st_row_active);
    cmd(read_autoprecharge_cmd, 1'b0, 11'h000);
    tick(2);
    check(state, st_read_autopre);
    tick(2);
    check(state, st_row_precharge);
    tick(3);
    check(state, st_idle);
    // Burst stop at latency three keeps data out one cycle longer
    cmd(mode_register_load_cmd, 1'b0, 11'h037);
    tick(3);
    check(cas_latency, 3'h3);
    cmd(bank_activate_cmd, 1'b0, 11'h077);
    tick(3);
    cmd(column_read_cmd, 1'b0, 11'h010);
    tick(5);
    cmd(burst_stop_cmd, 1'b0, 11'h000);
    tick(2);
    check(state, st_row_active);
    tick(2);
    check(dq_out_en, 1'b1);
    tick(1);
    check(dq_out_en, 1'b0);
    cmd(bank_precharge_cmd, 1'b0, 11'h000);
    tick(6);
    // Power-down ignores pins until clock enable rises
    req_cke = 1'b0;
    tick(3);
    check(state, st_power_down);
    cmd(bank_activate_cmd, 1'b0, 11'h011);
    tick(3);
    check(state, st_power_down);
    req_cke = 1'b1;
    tick(3);
    check(state, st_idle);
    tick(3);
    check(state, st_idle);
    // Refresh with clock enable falling enters self refresh
    req_cke = 1'b0;
    cmd(refresh_cmd, 1'b0, 11'h000);
    tick(2);
    check(state, st_self_refresh);
    check({illegal_cmd, refresh_pulse}, 2'h0);
    req_cke = 1'b1;
    tick(3);
    check(state, st_idle);
    // Reset in mid-run with a row open
    cmd(bank_activate_cmd, 1'b0, 11'h3cc);
    tick(3);
    nrst = 1'b0;
    tick(2);
    check({state, open_row, dq_out_en}, 16'h0000);
    check({burst_len_code, cas_latency}, 6'h02);
    nrst = 1'b1;
    tick(3);
    check(state, st_idle);
    cmd(bank_activate_cmd, 1'b0, 11'h0f0);
    tick(2);
    check(state, st_row_active);
    check(open_row, 11'h0f0);
    finish_test();
  end
endmodule : sdram_bank_command_state_machine_tb
`default_nettype wire
